//--- fault_status_pkg.sv
// constants for the fault status and power-good select register group
// assumes a 32-bit avalon-mm slave; one register per aligned word
package fault_status_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MISC_STATUS = 8'h74;
    localparam logic [7:0] IDX_MODERATE_ERROR = 8'h75;
    localparam logic [7:0] IDX_SEVERE_ERROR = 8'h76;
    localparam logic [7:0] IDX_READBACK_ERROR = 8'h77;
    localparam logic [7:0] IDX_PG_CONV_SELECT = 8'h78;
    localparam logic [7:0] IDX_PG_MISC_SELECT = 8'h7b;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h60;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h61;

    // miscellaneous status fields
    localparam int THERMAL_WARNING_BIT = 3;
    localparam int SYNC_CLOCK_INVALID_BIT = 1;
    // moderate error field
    localparam int SEQ_SHUTDOWN_BIT = 0;
    // severe error fields
    localparam int SUPPLY_OVERVOLTAGE_BIT = 1;
    localparam int IMM_SHUTDOWN_BIT = 0;
    // pin readback fields
    localparam int SOC_RESET_READBACK_BIT = 3;
    localparam int RESET_OUT_READBACK_BIT = 2;
    localparam int INT_PIN_READBACK_BIT = 1;
    localparam int DRIVE_EN_READBACK_BIT = 0;

    // converter select field: width of one field and its codes
    localparam int CONV_SEL_W = 2;
    localparam logic [1:0] CONV_SEL_MASKED = 2'h0;
    localparam logic [1:0] CONV_SEL_VOLTAGE = 2'h1;

    // misc select fields
    localparam int PG_WINDOW_BIT = 7;
    localparam int PG_POLARITY_BIT = 6;
    localparam int PG_SEL_SOC_RESET_BIT = 5;
    localparam int PG_SEL_RESET_OUT_BIT = 4;
    localparam int PG_SEL_THERMAL_BIT = 3;
    localparam int PG_SEL_MON2_BIT = 2;
    localparam int PG_SEL_MON1_BIT = 1;
    localparam int PG_SEL_SUPPLY_BIT = 0;

    // event status bits
    localparam int EV_THERMAL_WARNING = 0;
    localparam int EV_SYNC_CLOCK = 1;
    localparam int EV_SEQ_SHUTDOWN = 2;
    localparam int EV_IMM_SHUTDOWN = 3;
    localparam int EV_OVERVOLTAGE = 4;
    localparam int EV_READBACK = 5;
    localparam int EV_POWER_LOST = 6;

    // reset values
    localparam logic [7:0] RESET_STATUS = 8'h00;
    localparam logic [7:0] RESET_SELECT = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : fault_status_pkg

//--- fault_status_regs.sv
// fault status flags, pin readback checks and power-good source selection
// assumes all monitor and pin inputs are synchronous to ref_clk and that
// an avalon-mm master with waitrequest reaches the registers
//
// How it works
// [RULE1] misc bit 3 shows thermal warning now
// [RULE2] misc bit 1 shows sync clock invalid
// [RULE3] moderate bit 0 shows sequenced thermal shutdown
// [RULE4] severe bit 1 shows analog supply overvoltage
// [RULE5] severe bit 0 shows immediate thermal shutdown
// [RULE6] readback bit 3: soc reset low-driven reads high
// [RULE7] readback bit 2: reset output low-driven reads high
// [RULE8] readback bit 1: interrupt pin low-driven reads high
// [RULE9] readback bit 0: drive enable sense differs
// [RULE10] four 2-bit converter select fields, rw
// [RULE11] 00 masked, 01 voltage, 1x voltage and limit
// [RULE12] selects reset to zero, loaded from nvm
// [RULE13] window bit adds overvoltage check when set
// [RULE14] polarity bit inverts power-good output level
// [RULE15] flags live, reserved zero, status writes ignored
// [RULE16] power-good valid only when all selected ok
`timescale 1ns/1ns

module fault_status_regs #(
    parameter int ADDR_W = 10,
    parameter int NUM_CONV = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // monitor levels
    input wire logic thermalWarning,
    input wire logic thermalSeqShutdown,
    input wire logic thermalImmShutdown,
    input wire logic syncClockInvalid,
    input wire logic analogSupplyOver,
    input wire logic analogSupplyUnder,
    input wire logic [1:0] monitorOver,
    input wire logic [1:0] monitorUnder,
    // converter monitors
    input wire logic [NUM_CONV-1:0] convOver,
    input wire logic [NUM_CONV-1:0] convUnder,
    input wire logic [NUM_CONV-1:0] convCurrentLimit,
    // output pins: driven state and sensed level
    input wire logic socResetDriveLow,
    input wire logic socResetSense,
    input wire logic resetOutDriveLow,
    input wire logic resetOutSense,
    input wire logic intPinDriveLow,
    input wire logic intPinSense,
    input wire logic driveEnableDriven,
    input wire logic driveEnableSense,
    // nonvolatile defaults, loaded on a one-cycle strobe
    input wire logic nvmLoad,
    input wire logic [7:0] nvmConvSelect,
    input wire logic [7:0] nvmMiscSelect,
    // results
    output logic powerGood,
    output logic irq
);

    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 10 and 32");
        end
        if (NUM_CONV != 4) begin
            $error("NUM_CONV must be 4: one select register holds four");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] miscStatus_ff;
    logic [7:0] moderateStatus_ff;
    logic [7:0] severeStatus_ff;
    logic [7:0] readbackStatus_ff;
    logic [7:0] convSelect_ff;
    logic [7:0] miscSelect_ff;
    logic [7:0] eventStatus_ff;
    logic [7:0] eventMask_ff;
    logic [7:0] prevFlags_ff;
    logic [31:0] readData_ff;
    logic waitRequest_ff;
    logic powerGood_ff;
    logic irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // live status words; reserved bits tie to zero

    logic [7:0] nxt_miscStatus;
    logic [7:0] nxt_moderateStatus;
    logic [7:0] nxt_severeStatus;
    logic [7:0] nxt_readbackStatus;

    always_comb begin
        nxt_miscStatus = fault_status_pkg::RESET_STATUS;
        nxt_moderateStatus = fault_status_pkg::RESET_STATUS;
        nxt_severeStatus = fault_status_pkg::RESET_STATUS;
        nxt_readbackStatus = fault_status_pkg::RESET_STATUS;
        nxt_miscStatus[fault_status_pkg::THERMAL_WARNING_BIT] =
            thermalWarning; // [RULE1]
        nxt_miscStatus[fault_status_pkg::SYNC_CLOCK_INVALID_BIT] =
            syncClockInvalid; // [RULE2]
        nxt_moderateStatus[fault_status_pkg::SEQ_SHUTDOWN_BIT] =
            thermalSeqShutdown; // [RULE3]
        nxt_severeStatus[fault_status_pkg::SUPPLY_OVERVOLTAGE_BIT] =
            analogSupplyOver; // [RULE4]
        nxt_severeStatus[fault_status_pkg::IMM_SHUTDOWN_BIT] =
            thermalImmShutdown; // [RULE5]
        nxt_readbackStatus[fault_status_pkg::SOC_RESET_READBACK_BIT] =
            socResetDriveLow & socResetSense; // [RULE6]
        nxt_readbackStatus[fault_status_pkg::RESET_OUT_READBACK_BIT] =
            resetOutDriveLow & resetOutSense; // [RULE7]
        nxt_readbackStatus[fault_status_pkg::INT_PIN_READBACK_BIT] =
            intPinDriveLow & intPinSense; // [RULE8]
        nxt_readbackStatus[fault_status_pkg::DRIVE_EN_READBACK_BIT] =
            driveEnableDriven ^ driveEnableSense; // [RULE9]
    end

    // flags follow the present condition with one cycle of registering
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            miscStatus_ff <= fault_status_pkg::RESET_STATUS;
            moderateStatus_ff <= fault_status_pkg::RESET_STATUS;
            severeStatus_ff <= fault_status_pkg::RESET_STATUS;
            readbackStatus_ff <= fault_status_pkg::RESET_STATUS;
        end else begin
            miscStatus_ff <= nxt_miscStatus; // [RULE15]
            moderateStatus_ff <= nxt_moderateStatus; // [RULE15]
            severeStatus_ff <= nxt_severeStatus; // [RULE15]
            readbackStatus_ff <= nxt_readbackStatus; // [RULE15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode: one wait cycle, then the answer for exactly one cycle

    wire [7:0] regIndex = address[9:2];
    wire busRequest = read | write;
    wire accept = busRequest & waitRequest_ff;
    wire writeNow = write & ~waitRequest_ff;
    wire lowLane = byteenable[0];
    wire hitConvSel = regIndex == fault_status_pkg::IDX_PG_CONV_SELECT;
    wire hitMiscSel = regIndex == fault_status_pkg::IDX_PG_MISC_SELECT;
    wire hitEvStatus = regIndex == fault_status_pkg::IDX_EVENT_STATUS;
    wire hitEvMask = regIndex == fault_status_pkg::IDX_EVENT_MASK;
    wire upperZero = (ADDR_W == 10) ? 1'b1 : (address >> 10) == '0;
    wire wrConvSel = writeNow & lowLane & upperZero & hitConvSel;
    wire wrMiscSel = writeNow & lowLane & upperZero & hitMiscSel;
    wire wrEvStatus = writeNow & lowLane & upperZero & hitEvStatus;
    wire wrEvMask = writeNow & lowLane & upperZero & hitEvMask;
    wire [7:0] wrByte = writedata[7:0];

    logic [7:0] readByte;

    // unmapped indices read zero; status registers ignore writes
    always_comb begin
        readByte = fault_status_pkg::RESET_STATUS;
        if (upperZero) begin
            unique case (regIndex)
                fault_status_pkg::IDX_MISC_STATUS:
                    readByte = miscStatus_ff;
                fault_status_pkg::IDX_MODERATE_ERROR:
                    readByte = moderateStatus_ff;
                fault_status_pkg::IDX_SEVERE_ERROR:
                    readByte = severeStatus_ff;
                fault_status_pkg::IDX_READBACK_ERROR:
                    readByte = readbackStatus_ff;
                fault_status_pkg::IDX_PG_CONV_SELECT:
                    readByte = convSelect_ff;
                fault_status_pkg::IDX_PG_MISC_SELECT:
                    readByte = miscSelect_ff;
                fault_status_pkg::IDX_EVENT_STATUS:
                    readByte = eventStatus_ff;
                fault_status_pkg::IDX_EVENT_MASK:
                    readByte = eventMask_ff;
                default:
                    readByte = fault_status_pkg::RESET_STATUS;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            waitRequest_ff <= 1'b1;
            readData_ff <= fault_status_pkg::READ_ZERO;
        end else begin
            waitRequest_ff <= ~accept;
            if (accept && read) begin
                readData_ff <= {24'h000000, readByte};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select registers: zero at reset, nvm defaults on load strobe

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            convSelect_ff <= fault_status_pkg::RESET_SELECT; // [RULE12]
            miscSelect_ff <= fault_status_pkg::RESET_SELECT; // [RULE12]
            eventMask_ff <= fault_status_pkg::RESET_MASK;
        end else begin
            if (wrConvSel) begin
                convSelect_ff <= wrByte; // [RULE10]
            end else if (nvmLoad) begin
                convSelect_ff <= nvmConvSelect; // [RULE12]
            end
            if (wrMiscSel) begin
                miscSelect_ff <= wrByte;
            end else if (nvmLoad) begin
                miscSelect_ff <= nvmMiscSelect; // [RULE12]
            end
            if (wrEvMask) begin
                eventMask_ff <= wrByte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-good evaluation

    wire windowMode = miscSelect_ff[fault_status_pkg::PG_WINDOW_BIT];
    wire invertPg = miscSelect_ff[fault_status_pkg::PG_POLARITY_BIT];
    logic [NUM_CONV-1:0] convOk;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
            wire [1:0] sel = convSelect_ff[gi*2 +: 2]; // [RULE10]
            // overvoltage counts only in window mode
            wire voltOk = ~convUnder[gi] &
                ~(windowMode & convOver[gi]); // [RULE13]
            wire limitUsed = sel[1]; // [RULE11]
            assign convOk[gi] =
                (sel == fault_status_pkg::CONV_SEL_MASKED) |
                (voltOk & ~(limitUsed & convCurrentLimit[gi])); // [RULE11]
        end
    endgenerate

    wire supplyOk = ~analogSupplyUnder &
        ~(windowMode & analogSupplyOver); // [RULE13]
    wire mon1Ok = ~monitorUnder[0] & ~(windowMode & monitorOver[0]);
    wire mon2Ok = ~monitorUnder[1] & ~(windowMode & monitorOver[1]);
    // the reset pins, when selected, make power-good invalid while sensed low
    wire miscOk =
        (~miscSelect_ff[fault_status_pkg::PG_SEL_SOC_RESET_BIT] |
            socResetSense) &
        (~miscSelect_ff[fault_status_pkg::PG_SEL_RESET_OUT_BIT] |
            resetOutSense) &
        (~miscSelect_ff[fault_status_pkg::PG_SEL_THERMAL_BIT] |
            ~thermalWarning) &
        (~miscSelect_ff[fault_status_pkg::PG_SEL_MON2_BIT] | mon2Ok) &
        (~miscSelect_ff[fault_status_pkg::PG_SEL_MON1_BIT] | mon1Ok) &
        (~miscSelect_ff[fault_status_pkg::PG_SEL_SUPPLY_BIT] | supplyOk);
    wire allValid = (&convOk) & miscOk; // [RULE16]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powerGood_ff <= 1'b0;
        end else begin
            powerGood_ff <= allValid ^ invertPg; // [RULE14]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events: rising flags set sticky bits; write one clears, set wins

    logic [7:0] liveFlags;
    always_comb begin
        liveFlags = fault_status_pkg::RESET_STATUS;
        liveFlags[fault_status_pkg::EV_THERMAL_WARNING] = thermalWarning;
        liveFlags[fault_status_pkg::EV_SYNC_CLOCK] = syncClockInvalid;
        liveFlags[fault_status_pkg::EV_SEQ_SHUTDOWN] = thermalSeqShutdown;
        liveFlags[fault_status_pkg::EV_IMM_SHUTDOWN] = thermalImmShutdown;
        liveFlags[fault_status_pkg::EV_OVERVOLTAGE] = analogSupplyOver;
        liveFlags[fault_status_pkg::EV_READBACK] = |nxt_readbackStatus;
        liveFlags[fault_status_pkg::EV_POWER_LOST] = ~allValid;
    end

    wire [7:0] rising = liveFlags & ~prevFlags_ff;
    wire [7:0] clearBits = wrEvStatus ? wrByte : 8'h00;
    wire [7:0] nxt_eventStatus = (eventStatus_ff & ~clearBits) | rising;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prevFlags_ff <= fault_status_pkg::RESET_STATUS;
            eventStatus_ff <= fault_status_pkg::RESET_STATUS;
            irq_ff <= 1'b0;
        end else begin
            prevFlags_ff <= liveFlags;
            eventStatus_ff <= nxt_eventStatus;
            irq_ff <= |(nxt_eventStatus & eventMask_ff);
        end
    end

    assign readdata = readData_ff;
    assign waitrequest = waitRequest_ff;
    assign powerGood = powerGood_ff;
    assign irq = irq_ff;

endmodule : fault_status_regs

//--- fault_status_regs_sva.sv
// checker for the fault status and power-good select register group
// assumes ADDR_W of 10 and the one-wait-state bus answer of the slave
`timescale 1ns/1ns
module fault_status_regs_sva #(
    parameter int ADDR_W = 10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // monitors, defaults and result
    input wire logic analogSupplyOver,
    input wire logic thermalImmShutdown,
    input wire logic nvmLoad,
    input wire logic [7:0] nvmConvSelect,
    input wire logic [7:0] nvmMiscSelect,
    input wire logic powerGood
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);
//////////////////////////////////////////////////////////////////////////////
wire [7:0] idx = address[9:2];
wire rdAns = read && !waitrequest;
wire wrAns = write && !waitrequest && byteenable[0];
wire mapped = idx inside {8'h60, 8'h61, [8'h74:8'h78], 8'h7b};
logic [7:0] convSh_ff;
logic [7:0] miscSh_ff;
// shadow of the select registers; a bus write beats a default load
always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
        convSh_ff <= 8'h00;
        miscSh_ff <= 8'h00;
    end else begin
        if (wrAns && idx == 8'h78) convSh_ff <= writedata[7:0];
        else if (nvmLoad) convSh_ff <= nvmConvSelect;
        if (wrAns && idx == 8'h7b) miscSh_ff <= writedata[7:0];
        else if (nvmLoad) miscSh_ff <= nvmMiscSelect;
    end
end
wire selZero = convSh_ff == 8'h00 && miscSh_ff[5:0] == 6'h00;
//////////////////////////////////////////////////////////////////////////////
AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait state");
AST_ANSWER_SHORT: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("answer held longer than one cycle");
AST_UPPER_ZERO: assert property (readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
AST_UNMAPPED_ZERO: assert property (
    rdAns && !mapped |-> readdata == 32'h0)
    else $error("unmapped read not zero");
AST_MISC_RESERVED: assert property (
    rdAns && idx == 8'h74 |-> (readdata[7:0] & 8'hf5) == 8'h00)
    else $error("reserved misc status bits set");
AST_SEVERE_LIVE: assert property (rdAns && idx == 8'h76 |->
    readdata[7:0] == {6'h0, $past(analogSupplyOver, 2),
    $past(thermalImmShutdown, 2)})
    else $error("severe status does not follow monitors");
AST_CONV_READBACK: assert property (rdAns && idx == 8'h78 |->
    readdata[7:0] == $past(convSh_ff))
    else $error("converter select readback wrong");
AST_PG_MASKED: assert property (selZero |=>
    powerGood == !$past(miscSh_ff[6]))
    else $error("power good wrong with all sources masked");
endmodule : fault_status_regs_sva

//--- test_fault_status_regs.sv
// self-checking bench for the fault status register group
// assumes the slave answers through waitrequest; inputs move on clock edges
`timescale 1ns/1ns
module test_fault_status_regs;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0] byteenable = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic powerGood;
    logic irq;
    logic [29:0] stim = '0;
    logic nvmLoad = 1'b0;
    logic [7:0] nvmConv = '0;
    logic [7:0] nvmMisc = '0;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic [7:0] cs;
    logic [7:0] ms;
    logic [7:0] regs [8] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h7b,
        8'h60, 8'h61};
    always #5 ref_clk = ~ref_clk;
    fault_status_regs #(.ADDR_W(10), .NUM_CONV(4)) fault_status_regs_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .thermalWarning(stim[9]), .thermalSeqShutdown(stim[8]),
        .thermalImmShutdown(stim[7]), .syncClockInvalid(stim[6]),
        .analogSupplyOver(stim[5]), .analogSupplyUnder(stim[4]),
        .monitorOver(stim[3:2]), .monitorUnder(stim[1:0]),
        .convOver(stim[21:18]), .convUnder(stim[17:14]),
        .convCurrentLimit(stim[13:10]),
        .socResetDriveLow(stim[29]), .socResetSense(stim[28]),
        .resetOutDriveLow(stim[27]), .resetOutSense(stim[26]),
        .intPinDriveLow(stim[25]), .intPinSense(stim[24]),
        .driveEnableDriven(stim[23]), .driveEnableSense(stim[22]),
        .nvmLoad(nvmLoad), .nvmConvSelect(nvmConv), .nvmMiscSelect(nvmMisc),
        .powerGood(powerGood), .irq(irq));
//////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    // holds the request until waitrequest is sampled low
    task automatic bus_op(input logic wr, input logic [7:0] idx,
        input logic [7:0] data, input logic [3:0] be,
        output logic [31:0] dout);
        int n;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, data};
        byteenable <= be;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            check({31'h0, waitrequest}, 32'h0);
            finish_test();
        end
        dout = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus_op
    task automatic drive(input logic [31:0] r);
        @(posedge ref_clk);
        stim <= r[29:0];
        @(posedge ref_clk);
    endtask : drive
    // every selected source must be within its limits
    function automatic logic [31:0] expectGood(input logic [7:0] c,
        input logic [7:0] m, input logic [29:0] s);
        logic v;
        v = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (c[2*i+:2] != 2'h0) v &= !s[14+i] && !(m[7] && s[18+i]);
            if (c[2*i+1]) v &= !s[10+i];
        end
        if (m[0]) v &= !s[4] && !(m[7] && s[5]);
        if (m[1]) v &= !s[0] && !(m[7] && s[2]);
        if (m[2]) v &= !s[1] && !(m[7] && s[3]);
        if (m[3]) v &= !s[9];
        if (m[4]) v &= s[26];
        if (m[5]) v &= s[28];
        return {31'h0, v ^ m[6]};
    endfunction : expectGood
//////////////////////////////////////////////////////////////////////////////
    initial begin
        rd = $urandom(83);
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (regs[i]) begin
            bus_op(1'b0, regs[i], 8'h00, 4'hf, rd);
            check(rd, 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            drive($urandom);
            bus_op(1'b0, 8'h74, 8'h00, 4'hf, rd);
            check(rd, {28'h0, stim[9], 1'b0, stim[6], 1'b0});
            bus_op(1'b0, 8'h75, 8'h00, 4'hf, rd);
            check(rd, {31'h0, stim[8]});
            bus_op(1'b0, 8'h76, 8'h00, 4'hf, rd);
            check(rd, {30'h0, stim[5], stim[7]});
            bus_op(1'b0, 8'h77, 8'h00, 4'hf, rd);
            check(rd[3], stim[29] & stim[28]);
            check(rd[2], stim[27] & stim[26]);
            check(rd[1], stim[25] & stim[24]);
            check(rd[0], stim[23] ^ stim[22]);
            check(rd[31:4], 28'h0);
            bus_op(1'b1, 8'h74 + 8'(i % 4), 8'hff, 4'h1, rd);
        end
        for (int i = 0; i < 16; i++) begin
            cs = (i == 0) ? 8'h00 : 8'($urandom);
            ms = 8'($urandom) & ((i == 0) ? 8'hc0 : 8'hff);
            bus_op(1'b1, 8'h78, cs, 4'h1, rd);
            bus_op(1'b1, 8'h78, ~cs, 4'he, rd);
            bus_op(1'b1, 8'h7b, ms, 4'h1, rd);
            bus_op(1'b1, 8'h79, 8'hff, 4'h1, rd);
            drive($urandom);
            repeat (2) @(posedge ref_clk);
            check({31'h0, powerGood},
                expectGood(cs, ms, stim));
            bus_op(1'b0, 8'h78, 8'h00, 4'hf, rd);
            check(rd, {24'h0, cs});
            bus_op(1'b0, 8'h7b, 8'h00, 4'hf, rd);
            check(rd, {24'h0, ms});
            bus_op(1'b0, 8'h79, 8'h00, 4'hf, rd);
            check(rd, 32'h0);
        end
        @(posedge ref_clk);
        nvmLoad <= 1'b1;
        nvmConv <= 8'($urandom);
        nvmMisc <= 8'($urandom);
        @(posedge ref_clk);
        nvmLoad <= 1'b0;
        bus_op(1'b0, 8'h78, 8'h00, 4'hf, rd);
        check(rd, {24'h0, nvmConv});
        bus_op(1'b0, 8'h7b, 8'h00, 4'hf, rd);
        check(rd, {24'h0, nvmMisc});
        // at most the warning event is unmasked from here on
        drive(32'h0);
        bus_op(1'b1, 8'h61, 8'h01, 4'h1, rd);
        bus_op(1'b1, 8'h60, 8'h7f, 4'h1, rd);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        drive(32'h200);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h1);
        bus_op(1'b0, 8'h60, 8'h00, 4'hf, rd);
        check({31'h0, rd[0]}, 32'h1);
        bus_op(1'b1, 8'h61, 8'h00, 4'h1, rd);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        bus_op(1'b1, 8'h61, 8'h01, 4'h1, rd);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h1);
        // cleared while the warning persists: no new rising edge
        bus_op(1'b1, 8'h60, 8'h01, 4'h1, rd);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        finish_test();
    end
endmodule : test_fault_status_regs
bind fault_status_regs fault_status_regs_sva #(.ADDR_W(ADDR_W))
    fault_status_regs_sva_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .analogSupplyOver(analogSupplyOver),
    .thermalImmShutdown(thermalImmShutdown), .nvmLoad(nvmLoad),
    .nvmConvSelect(nvmConvSelect), .nvmMiscSelect(nvmMiscSelect),
    .powerGood(powerGood));
